// [inc/ssc_pkg.sv]
// Package for the serial collision-fault peripheral: offsets, fields, states
package ssc_pkg;
   // Word byte addresses on the register bus
   localparam logic [3:0] DATA_OFS    = 4'h0;
   localparam logic [3:0] CTRL_OFS    = 4'h4;
   localparam logic [3:0] STAT_OFS    = 4'h8;
   localparam logic [3:0] PRESC_OFS   = 4'hc;
   localparam logic [3:0] IRQ_OFS     = 4'h0;
   // Control register field positions
   localparam int CTL_IRQ_EN      = 7;
   localparam int CTL_OUT_EN      = 6;
   localparam int CTL_IRQ_SRC     = 5;
   localparam int CTL_MASTER      = 4;
   localparam int CTL_CLOCK_POLARITY        = 3;
   localparam int CTL_CLOCK_PHASE        = 2;
   // Status register field positions
   localparam int STS_DONE        = 7;
   localparam int STS_WRITE_COLLISION_FLAG        = 6;
   localparam int STS_MODE_FAULT_FLAG        = 4;
   // Reset values and last bit count
   localparam logic [7:0] BYTE_RST  = 8'h00;
   localparam logic [2:0] CNT_RST   = 3'h0;
   localparam logic [2:0] CNT_LAST  = 3'h7;
   localparam logic [4:0] DIV_RST   = 5'h00;
   // Master clock divide per rate select
   localparam logic [4:0] DIV_2  = 5'h00;
   localparam logic [4:0] DIV_4  = 5'h01;
   localparam logic [4:0] DIV_16 = 5'h07;
   localparam logic [4:0] DIV_32 = 5'h0f;

   // Serial pins seen by the block
   typedef struct packed {
      logic sck;
      logic mosi;
      logic miso;
      logic ss_n;
   } ssc_pins_s;

   // Pin drive: value and output enable for SCK, MOSI and MISO
   typedef struct packed {
      logic sck;
      logic sck_oe;
      logic mosi;
      logic mosi_oe;
      logic miso;
      logic miso_oe;
   } ssc_drive_s;

   typedef enum logic [1:0] {ST_IDLE, ST_RUN} ssc_xfer_e;
endpackage

// [rtl/ssc_core.sv]
// Byte-oriented serial peripheral with collision and mode fault protection
// Operation
// RULE1: Slave uses SCK, drives MISO, reads MOSI
// RULE2: Data write loads shifter, sent MSB first
// RULE3: Slave transfer starts on master clock
// RULE4: Done flag; interrupt needs source and enable
// RULE5: Final edge copies shifter to receive buffer
// RULE6: Status access then data read clears done
// RULE7: Data writes ignored while done, until status read
// RULE8: Exactly eight clock pulses per byte
// RULE9: Polarity sets SCK idle level
// RULE10: Phase set: second edge captures MSB
// RULE11: Phase clear: first edge captures MSB
// RULE12: Select low freezes data register in slave
// RULE13: Master toggles select between bytes, phase clear
// RULE14: Phase set: first edge freezes, drives MSB
// RULE15: Collision keeps transfer, drops write, flags
// RULE16: Phase clear slave: write after select low
// RULE17: Master: write while clock runs collides
// RULE18: Select low in master: fault, drop enables
// RULE19: Status read then control write clears fault
// RULE20: Fault blocks enables except clearing write
// RULE21: Fault never set in slave mode
// RULE22: Overrun keeps last byte, no indication; code keeps the first byte since the last done clear
// RULE23: Status read then data access clears collision
module ssc_core
   import ssc_pkg::*;
(
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   // Wishbone slave
   input  wire logic              cyc_i,
   input  wire logic              stb_i,
   input  wire logic              we_i,
   input  wire logic [3:0]        adr_i,
   input  wire logic [3:0]        sel_i,
   input  wire logic [31:0]       dat_i,
   output logic      [31:0]       dat_o,
   output logic                   ack_o,
   // Serial pins
   input  wire ssc_pkg::ssc_pins_s pins_i,
   output ssc_pkg::ssc_drive_s    drive_o,
   // Interrupt request
   output logic                   irq_o
);
   import ssc_pkg::*;

   // All module state
   typedef struct packed {
      logic [7:0]  ctrl;
      logic [7:0]  presc;
      logic [7:0]  shift;
      logic [7:0]  rxbuf;
      logic [2:0]  cnt;
      logic        done;
      logic        write_collision_flag;
      logic        mode_fault_flag;
      logic        done_armed;
      logic        write_collision_flag_armed;
      logic        mode_fault_flag_armed;
      logic        sck_prev;
      logic        ss_prev;
      logic        edge_odd;
      logic        in_bit;
      logic [4:0]  div;
      logic        mck;
      ssc_xfer_e   st;
      logic [31:0] rdat;
      logic        ack;
      logic        irq;
      ssc_drive_s  drv;
   } ssc_state_s;

   ssc_state_s s_q, s_d;

   // Master half-period count from the rate select
   function automatic logic [4:0] half_div(input logic [1:0] rs);
      unique case (rs)
         2'b00: half_div = DIV_2;
         2'b01: half_div = DIV_4;
         2'b10: half_div = DIV_16;
         2'b11: half_div = DIV_32;
      endcase
   endfunction

   logic       acc, wr_acc, rd_acc, lane0;
   logic       is_data, is_ctrl, is_stat, is_presc;
   logic       master, clock_polarity, clock_phase;
   logic       sck_in, sck_rise, sck_fall, lead_edge, trail_edge;
   logic       cap_edge, drv_edge, ss_low;
   logic [7:0] status, ctrl_w;
   logic       busy, data_wr, collide, mstep;

   // Combinational next state
   always_comb begin
      s_d      = s_q;
      acc      = cyc_i & stb_i & ~s_q.ack;
      wr_acc   = acc & we_i;
      rd_acc   = acc & ~we_i;
      lane0    = sel_i[0];
      is_data  = adr_i == DATA_OFS;
      is_ctrl  = adr_i == CTRL_OFS;
      is_stat  = adr_i == STAT_OFS;
      is_presc = adr_i == PRESC_OFS;
      master   = s_q.ctrl[CTL_MASTER];
      clock_polarity     = s_q.ctrl[CTL_CLOCK_POLARITY];
      clock_phase     = s_q.ctrl[CTL_CLOCK_PHASE];
      ss_low   = ~pins_i.ss_n;
      busy     = s_q.st == ST_RUN;
      status   = {s_q.done, s_q.write_collision_flag, 1'b0, s_q.mode_fault_flag, 4'h0};
      ctrl_w   = dat_i[7:0];
      mstep    = 1'b0;

      // Shift clock source: own divider in master, SCK pin in slave
      if (master) begin
         sck_in = s_q.mck;
         if (busy) begin
            if (s_q.div == half_div(s_q.ctrl[1:0])) begin
               s_d.div = DIV_RST;
               s_d.mck = ~s_q.mck;
               mstep   = 1'b1;
            end else begin
               s_d.div = s_q.div + 5'h01;
            end
         end else begin
            s_d.div = DIV_RST;
            s_d.mck = clock_polarity;                          // RULE9
         end
      end else begin
         sck_in  = pins_i.sck;                       // RULE1
         s_d.div = DIV_RST;
         s_d.mck = clock_polarity;
      end
      s_d.sck_prev = sck_in;
      s_d.ss_prev  = pins_i.ss_n;
      sck_rise   = sck_in & ~s_q.sck_prev;
      sck_fall   = ~sck_in & s_q.sck_prev;
      // Leading edge leaves the idle level set by polarity
      lead_edge  = clock_polarity ? sck_fall : sck_rise;       // RULE9
      trail_edge = clock_polarity ? sck_rise : sck_fall;
      cap_edge   = clock_phase ? trail_edge : lead_edge;    // RULE10 RULE11
      drv_edge   = clock_phase ? lead_edge : trail_edge;
      if (!master && pins_i.ss_n) begin
         cap_edge = 1'b0;
         drv_edge = 1'b0;
      end

      // Slave starts on the first clock edge while selected
      if (!master && !busy && ss_low && (lead_edge | trail_edge)) begin
         s_d.st = ST_RUN;                            // RULE3 RULE14
      end

      // Serial shifting: capture into in_bit, shift on the drive edge
      if (cap_edge && (busy || s_d.st == ST_RUN)) begin
         s_d.in_bit = master ? pins_i.miso : pins_i.mosi;
         if (s_q.cnt == CNT_LAST) begin
            // Last capture ends the byte
            // Overrun keeps the first byte since the last clear
            if (!s_q.done) begin
               s_d.rxbuf = {s_q.shift[6:0], s_d.in_bit};  // RULE5 RULE22
            end
            s_d.shift = {s_q.shift[6:0], s_d.in_bit};
            s_d.done  = 1'b1;                        // RULE4
            s_d.cnt   = CNT_RST;                     // RULE8
            s_d.st    = ST_IDLE;
         end else begin
            s_d.cnt = s_q.cnt + 3'h1;
         end
      end
      if (drv_edge && busy && s_q.cnt != CNT_RST) begin
         s_d.shift = {s_q.shift[6:0], s_q.in_bit};
      end else if (drv_edge && busy && clock_phase && s_q.cnt == CNT_RST && !master) begin
         s_d.shift = s_q.shift;                      // RULE14
      end
      // Phase clear: MSB capture already shifted on first drive edge
      if (drv_edge && busy && s_q.cnt != CNT_RST) begin
         s_d.shift = {s_q.shift[6:0], s_q.in_bit};   // RULE2
      end

      // Pin drive
      s_d.drv.sck     = s_q.mck;
      s_d.drv.sck_oe  = s_q.ctrl[CTL_OUT_EN] & master;
      s_d.drv.mosi    = s_d.shift[7];
      s_d.drv.mosi_oe = s_q.ctrl[CTL_OUT_EN] & master;
      s_d.drv.miso    = s_d.shift[7];                // RULE2
      s_d.drv.miso_oe = s_q.ctrl[CTL_OUT_EN] & ~master & ss_low;  // RULE1

      // Write collision window per mode
      if (master) begin
         collide = busy;                             // RULE17
      end else if (clock_phase) begin
         collide = busy;                             // RULE14
      end else begin
         collide = ss_low | busy;                    // RULE12 RULE16
      end

      // Register bus
      s_d.ack  = acc;
      s_d.rdat = 32'h0;
      data_wr  = wr_acc & is_data & lane0;
      if (rd_acc) begin
         unique case (1'b1)
            is_data:  s_d.rdat = {24'h0, s_q.rxbuf};  // RULE5
            is_ctrl:  s_d.rdat = {24'h0, s_q.ctrl};
            is_stat:  s_d.rdat = {24'h0, status};
            is_presc: s_d.rdat = {24'h0, s_q.presc};
            default:  s_d.rdat = 32'h0;
         endcase
      end
      if (acc && is_stat) begin
         s_d.done_armed = s_q.done;                  // RULE6
         s_d.write_collision_flag_armed = s_q.write_collision_flag;
         s_d.mode_fault_flag_armed = s_q.mode_fault_flag & ~we_i;
      end
      // Data register write
      if (data_wr) begin
         if (s_q.done && !s_q.done_armed) begin
            s_d.shift = s_q.shift;                   // RULE7
         end else if (collide) begin
            s_d.write_collision_flag  = 1'b1;                        // RULE15
         end else begin
            s_d.shift    = dat_i[7:0];               // RULE2
            s_d.drv.miso = dat_i[7];
            s_d.drv.mosi = dat_i[7];
            if (master) begin
               s_d.st  = ST_RUN;
               s_d.cnt = CNT_RST;
            end
         end
      end
      // Flag clearing sequences; a hardware set this cycle wins
      if (rd_acc && is_data && s_q.done_armed && !(s_d.done && !s_q.done)) begin
         s_d.done       = 1'b0;                      // RULE6
         s_d.done_armed = 1'b0;
      end
      if (acc && is_data && s_q.write_collision_flag_armed && !(collide && data_wr)) begin
         s_d.write_collision_flag       = 1'b0;                      // RULE23
         s_d.write_collision_flag_armed = 1'b0;
      end
      // Control register write
      if (wr_acc && is_ctrl && lane0) begin
         if (s_q.mode_fault_flag && !s_q.mode_fault_flag_armed) begin
            ctrl_w[CTL_OUT_EN] = 1'b0;               // RULE20
            ctrl_w[CTL_MASTER] = 1'b0;
         end
         s_d.ctrl = ctrl_w;
         if (s_q.mode_fault_flag_armed) begin
            s_d.mode_fault_flag       = 1'b0;                   // RULE19
            s_d.mode_fault_flag_armed = 1'b0;
         end
      end
      if (wr_acc && is_presc && lane0) begin
         s_d.presc = dat_i[7:0];
      end
      // Mode fault only while master
      if (master && ss_low) begin
         s_d.mode_fault_flag               = 1'b1;              // RULE18 RULE21
         s_d.ctrl[CTL_OUT_EN]   = 1'b0;
         s_d.ctrl[CTL_MASTER]   = 1'b0;
         s_d.st                 = ST_IDLE;
         s_d.cnt                = CNT_RST;
      end
      // Slave deselected mid-byte aborts the partial byte
      if (!master && pins_i.ss_n && busy) begin
         s_d.st  = ST_IDLE;
         s_d.cnt = CNT_RST;
      end

      // Interrupt request from the done or mode fault flag
      s_d.irq = s_q.ctrl[CTL_IRQ_EN] & s_q.ctrl[CTL_IRQ_SRC] &
                (s_q.done | s_q.mode_fault_flag);              // RULE4 RULE18
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from flip-flops
   assign dat_o   = s_q.rdat;
   assign ack_o   = s_q.ack;
   assign irq_o   = s_q.irq;
   assign drive_o = s_q.drv;
endmodule

// [bench/ssc_core_properties.sv]
// Checker for bus answers, pin roles and fault reactions of the serial block
module ssc_core_properties
   import ssc_pkg::*;
(
   // Clock and reset
   input wire logic                clk_i,
   input wire logic                rst_i,
   // Register bus
   input wire logic                cyc_i,
   input wire logic                stb_i,
   input wire logic                we_i,
   input wire logic [3:0]          adr_i,
   input wire logic [31:0]         dat_o,
   input wire logic                ack_o,
   // Pins and interrupt
   input wire ssc_pkg::ssc_pins_s  pins_i,
   input wire ssc_pkg::ssc_drive_s drive_o,
   input wire logic                irq_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Bus answer timing and quiet outputs after reset
   ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
   ack_follow_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("request not answered");
   ack_cause_a: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i)) else $error("ack without request");
   reset_quiet_a: assert property ($fell(rst_i) |-> !ack_o && !irq_o && drive_o == '0) else $error("outputs live");
   // Pin roles and faults
   pin_roles_a: assert property (drive_o.miso_oe |-> !drive_o.sck_oe && !drive_o.mosi_oe)
      else $error("slave drives master pins");
   fault_drop_a: assert property (drive_o.sck_oe && !pins_i.ss_n |-> ##[1:3] (!drive_o.sck_oe && !drive_o.mosi_oe))
      else $error("pins kept after fault");
   miso_hold_a: assert property ((drive_o.miso_oe && !pins_i.ss_n && $stable(pins_i.sck)) [*5]
      |-> $stable(drive_o.miso)) else $error("slave output moved without clock");
   stat_spare_a: assert property (ack_o && $past(cyc_i && !we_i && adr_i == STAT_OFS)
      |-> dat_o[5] == 1'b0 && dat_o[3:0] == 4'h0) else $error("spare status bits set");
   slave_mode_fault_flag_a: assert property (ack_o && $past(cyc_i && !we_i && adr_i == STAT_OFS) && drive_o.miso_oe
      |-> !dat_o[STS_MODE_FAULT_FLAG]) else $error("fault flag in enabled slave");
   // Main scenarios
   cover property ($rose(irq_o));
   cover property (drive_o.sck_oe && !pins_i.ss_n);
   cover property (ack_o && dat_o[STS_WRITE_COLLISION_FLAG]);
endmodule

bind ssc_core ssc_core_properties u_ssc_core_properties (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_o,
   .ack_o, .pins_i, .drive_o, .irq_o);

// [bench/ssc_spi_master.sv]
// Far side model: a serial master clocking whole bytes through the slave
module ssc_spi_master
#(
   parameter int HALF = 6
)
(
   // Clock and mode
   input  wire logic clk_i,
   input  wire logic clock_polarity_i,
   input  wire logic clock_phase_i,
   // Serial lines
   input  wire logic miso_i,
   output logic      sck_o,
   output logic      mosi_o,
   output logic      ss_n_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic miso_q;
   initial begin
      sck_o = 1'b0;
      mosi_o = 1'b0;
      ss_n_o = 1'b1;
   end
   // Clock rests at its idle level outside frames
   always @(posedge clk_i) if (ss_n_o) sck_o <= clock_polarity_i;
   // Sample half a cycle early so the answer has settled
   always @(negedge clk_i) miso_q <= miso_i;
   task automatic sel(input logic v);
      @(posedge clk_i);
      ss_n_o <= v;
   endtask
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      ss_n_o <= 1'b0;
      mosi_o <= tx[7];
      repeat (HALF) @(posedge clk_i);
      for (int i = 7; i >= 0; i--) begin
         if (clock_phase_i) mosi_o <= tx[i];
         else rx[i] = miso_q;
         sck_o <= ~clock_polarity_i;
         repeat (HALF) @(posedge clk_i);
         if (clock_phase_i) rx[i] = miso_q;
         else if (i > 0) mosi_o <= tx[i-1];
         sck_o <= clock_polarity_i;
         repeat (HALF) @(posedge clk_i);
      end
      ss_n_o <= 1'b1;
      mosi_o <= ~mosi_o;
   endtask
endmodule

// [bench/ssc_core_tb_top.sv]
// Self-checking bench: registers, slave bytes, collisions and mode fault
module ssc_core_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import ssc_pkg::*;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc_i = 1'b0;
   logic        stb_i = 1'b0;
   logic        we_i = 1'b0;
   logic [3:0]  adr_i = 4'h0;
   logic [31:0] dat_i = 32'h0;
   logic [31:0] dat_o;
   logic        ack_o;
   logic        irq_o;
   logic        sck;
   logic        mosi;
   logic        ss_n;
   logic        clock_polarity = 1'b0;
   logic        clock_phase = 1'b0;
   ssc_pins_s   pins_i;
   ssc_drive_s  drive_o;
   logic [7:0]  exp_q[$];
   logic [7:0]  tx, rx1, rx2, got;
   int          failures = 0;
   int          tests_run = 0;
   int          cycles = 0;
   always #10 clk_i = ~clk_i;
   // Wire levels from every party's enable; far side echoes our output
   assign pins_i = {drive_o.sck_oe ? drive_o.sck : sck, drive_o.mosi_oe ? drive_o.mosi : mosi,
                    drive_o.miso_oe ? drive_o.miso : drive_o.mosi, ss_n};
   ssc_core u_ssc_core (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i(4'h1), .dat_i, .dat_o, .ack_o,
      .pins_i, .drive_o, .irq_o);
   ssc_spi_master u_ssc_spi_master (.clk_i, .clock_polarity_i(clock_polarity), .clock_phase_i(clock_phase), .miso_i(pins_i.miso), .sck_o(sck),
      .mosi_o(mosi), .ss_n_o(ss_n));
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      tests_run++;
      if (seen !== want) begin
         failures++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= {24'h0, d};
      do @(posedge clk_i); while (ack_o !== 1'b1);
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] want);
      exp_q.push_back(want);
      wb(1'b0, a, 8'h00);
   endtask
   // Read answers are compared against the oldest note
   always @(posedge clk_i) if (ack_o === 1'b1 && we_i === 1'b0) check(dat_o[7:0], exp_q.pop_front());
   // Hang guard
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 8000) begin
         failures++;
         wrap_up();
      end
   end
   initial begin
      tx = $urandom(25822);
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      check({2'b0, drive_o}, 8'h00);
      rd(DATA_OFS, 8'h00);
      rd(CTRL_OFS, 8'h00);
      rd(STAT_OFS, 8'h00);
      wb(1'b1, 4'h2, 8'hff);
      rd(4'h2, 8'h00);
      wb(1'b1, PRESC_OFS, 8'h5a);
      // All four clock modes as slave, with an ignored write and an overrun
      for (int m = 0; m < 4; m++) begin
         clock_polarity <= m[1];
         clock_phase <= ~m[0];
         wb(1'b1, CTRL_OFS, {4'he, m[1], ~m[0], 2'b11});
         tx = $urandom;
         rx1 = $urandom;
         rx2 = $urandom;
         wb(1'b1, DATA_OFS, tx);
         u_ssc_spi_master.xfer(rx1, got);
         check(got, tx);
         repeat (4) @(posedge clk_i);
         check({7'h0, irq_o}, 8'h01);
         wb(1'b1, DATA_OFS, ~tx);
         u_ssc_spi_master.xfer(rx2, got);
         check(got, rx1);
         repeat (4) @(posedge clk_i);
         rd(STAT_OFS, 8'h80);
         rd(DATA_OFS, rx1);
         rd(STAT_OFS, 8'h00);
      end
      // Phase-clear slave written while selected
      u_ssc_spi_master.sel(1'b0);
      wb(1'b1, DATA_OFS, tx);
      repeat (4) @(posedge clk_i);
      u_ssc_spi_master.sel(1'b1);
      rd(STAT_OFS, 8'h40);
      check({7'h0, irq_o}, 8'h00);
      rd(DATA_OFS, rx1);
      u_ssc_spi_master.xfer(8'h00, got);
      check(got, rx2);
      rd(STAT_OFS, 8'h80);
      rd(DATA_OFS, 8'h00);
      // Master byte with a colliding second write
      wb(1'b1, CTRL_OFS, 8'h53);
      wb(1'b1, DATA_OFS, tx);
      wb(1'b1, DATA_OFS, ~tx);
      repeat (300) @(posedge clk_i);
      check({6'h0, drive_o.sck_oe, drive_o.sck}, 8'h02);
      rd(STAT_OFS, 8'hc0);
      rd(DATA_OFS, tx);
      rd(STAT_OFS, 8'h00);
      // Select pulled low while master
      wb(1'b1, CTRL_OFS, 8'hf0);
      u_ssc_spi_master.sel(1'b0);
      repeat (4) @(posedge clk_i);
      check({6'h0, drive_o.sck_oe, irq_o}, 8'h01);
      u_ssc_spi_master.sel(1'b1);
      wb(1'b1, CTRL_OFS, 8'hf0);
      rd(CTRL_OFS, 8'ha0);
      rd(STAT_OFS, 8'h10);
      wb(1'b1, CTRL_OFS, 8'h00);
      rd(STAT_OFS, 8'h00);
      wrap_up();
   end
endmodule
